// ### pkg/dpg_pkg.sv
// Package with register map, field positions and reset values for the dual port pin block
// Functional notes
// - Port one bits 0-3 full seven controls
// - Port one 0-3 select: timer clock, outputs, captures
// - Port one 4-7 select: subsystem clock, timer outputs
// - Port two bits 0-4 full seven controls
// - Port two select: aux clock, alt clock, captures
// - Direction register alone enables every pad driver except port two bit 5, which resistor control also disables
// - Alternate signals connect to the 16-bit timer
// - Port two bit 5 selected drives low
// - Resistor control disconnects port two bit 5
// - Port two bits 6-7 padless, output low
// - Padless flags change only by software writes
package dpg_pkg;
    // Register byte offsets, port one then port two
    localparam logic [7:0] DPG_P1_IN = 8'h00;
    localparam logic [7:0] DPG_P1_OUT = 8'h04;
    localparam logic [7:0] DPG_P1_DIR = 8'h08;
    localparam logic [7:0] DPG_P1_IFG = 8'h0C;
    localparam logic [7:0] DPG_P1_IES = 8'h10;
    localparam logic [7:0] DPG_P1_IE = 8'h14;
    localparam logic [7:0] DPG_P1_SEL = 8'h18;
    localparam logic [7:0] DPG_P2_IN = 8'h20;
    localparam logic [7:0] DPG_P2_OUT = 8'h24;
    localparam logic [7:0] DPG_P2_DIR = 8'h28;
    localparam logic [7:0] DPG_P2_IFG = 8'h2C;
    localparam logic [7:0] DPG_P2_IES = 8'h30;
    localparam logic [7:0] DPG_P2_IE = 8'h34;
    localparam logic [7:0] DPG_P2_SEL = 8'h38;
    // Reset value of every control register
    localparam logic [7:0] DPG_RST_VAL = 8'h00;
    // Port two bits that raise flags from pad edges (bits 6 and 7 never do)
    localparam logic [7:0] DPG_P2_PAD_MASK = 8'h3F;
    // Port two bit with the oscillator resistor function
    localparam int DPG_P2_OSC_RESISTOR_PIN_BIT = 5;
    // AXI response codes
    localparam logic [1:0] DPG_RESP_OKAY = 2'h0;
    localparam logic [1:0] DPG_RESP_SLVERR = 2'h2;
endpackage

// ### hdl/dpg_port.sv
// One 8-bit port: control registers, pad mux, input sync and edge flags
`timescale 1ns/100ps
module dpg_port #(
    parameter logic [7:0] EDGE_MASK = 8'hFF
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_out_i,
    input wire logic wr_dir_i,
    input wire logic wr_ifg_i,
    input wire logic wr_ies_i,
    input wire logic wr_ie_i,
    input wire logic wr_sel_i,
    input wire logic [7:0] pad_in_i,
    input wire logic [7:0] periph_out_i,
    output logic [7:0] in_o,
    output logic [7:0] out_o,
    output logic [7:0] dir_o,
    output logic [7:0] ifg_o,
    output logic [7:0] ies_o,
    output logic [7:0] ie_o,
    output logic [7:0] sel_o,
    output logic [7:0] pad_drive_o,
    output logic [7:0] pad_oe_n_o,
    output logic irq_o
);
    logic [7:0] sync1_reg; // First stage, read only by second stage
    logic [7:0] sync2_reg; // Synchronized pad level
    logic [7:0] prev_reg; // Previous synchronized level for edges
    logic [7:0] rise; // Rising edges
    logic [7:0] fall; // Falling edges
    logic [7:0] edge_hit; // Edge chosen by edge select, per bit
    logic [7:0] ifg_next;
    logic [7:0] drive_next;

    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;
    // Edge select 0 picks rising, 1 picks falling
    assign edge_hit = ((rise & ~ies_o) | (fall & ies_o)) & EDGE_MASK;
    // Set wins over a software write in the same cycle
    assign ifg_next = (wr_ifg_i ? wdata_i : ifg_o) | edge_hit;
    // Output register or peripheral signal per select bit
    assign drive_next = (sel_o & periph_out_i) | (~sel_o & out_o);

    // Synchronizer and edge history
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_reg <= dpg_pkg::DPG_RST_VAL;
            sync2_reg <= dpg_pkg::DPG_RST_VAL;
            prev_reg <= dpg_pkg::DPG_RST_VAL;
        end else begin
            sync1_reg <= pad_in_i;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Control registers, each loaded by its write strobe
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_o <= dpg_pkg::DPG_RST_VAL;
            dir_o <= dpg_pkg::DPG_RST_VAL;
            ies_o <= dpg_pkg::DPG_RST_VAL;
            ie_o <= dpg_pkg::DPG_RST_VAL;
            sel_o <= dpg_pkg::DPG_RST_VAL;
            ifg_o <= dpg_pkg::DPG_RST_VAL;
        end else begin
            if (wr_out_i) out_o <= wdata_i;
            if (wr_dir_i) dir_o <= wdata_i;
            if (wr_ies_i) ies_o <= wdata_i;
            if (wr_ie_i) ie_o <= wdata_i;
            if (wr_sel_i) sel_o <= wdata_i;
            ifg_o <= ifg_next;
        end
    end

    // Pad outputs, input image and interrupt request, all registered
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pad_drive_o <= dpg_pkg::DPG_RST_VAL;
            pad_oe_n_o <= 8'hFF;
            in_o <= dpg_pkg::DPG_RST_VAL;
            irq_o <= 1'b0;
        end else begin
            pad_drive_o <= drive_next;
            // Direction alone drives the enable, even in peripheral mode
            pad_oe_n_o <= (wr_dir_i ? ~wdata_i : ~dir_o);
            in_o <= sync2_reg;
            irq_o <= |(ifg_next & (wr_ie_i ? wdata_i : ie_o));
        end
    end
endmodule

// ### hdl/dpg_gpio.sv
// Top of the dual port pin block: AXI4-Lite slave, function routing, two ports
`timescale 1ns/100ps
module dpg_gpio (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port one pads
    input wire logic [7:0] port_one_pad_i,
    output logic [7:0] port_one_pad_o,
    output logic [7:0] port_one_pad_oe_n_o,
    // Port two pads, bits 0 to 5 only
    input wire logic [5:0] port_two_pad_i,
    output logic [5:0] port_two_pad_o,
    output logic [5:0] port_two_pad_oe_n_o,
    // Timer and clock module side
    input wire logic timer_output_0_i,
    input wire logic timer_output_1_i,
    input wire logic timer_output_2_i,
    input wire logic subsystem_clock_i,
    input wire logic aux_clock_i,
    input wire logic ext_resistor_select_i,
    output logic timer_ext_clock_in_o,
    output logic timer_alt_clock_in_o,
    output logic capture0_input_a_o,
    output logic capture1_input_a_o,
    output logic capture2_input_a_o,
    output logic capture0_input_b_o,
    output logic capture1_input_b_o,
    output logic port_one_irq_o,
    output logic port_two_irq_o
);
    // Write channel holding registers
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [7:0] araddr_q;
    logic [1:0] rresp_next;
    logic [31:0] rdata_next;
    logic wr_fire; // Both halves present and response slot free
    logic wr_lane0; // Low byte lane enabled
    logic wr_hit; // Write address is mapped
    logic [7:0] wr_data;
    logic rd_fire;
    // Per-register write strobes
    logic w1_out, w1_dir, w1_ifg, w1_ies, w1_ie, w1_sel;
    logic w2_out, w2_dir, w2_ifg, w2_ies, w2_ie, w2_sel;
    // Register views of both ports
    logic [7:0] p1_in, p1_out, p1_dir, p1_ifg, p1_ies, p1_ie, p1_sel;
    logic [7:0] p2_in, p2_out, p2_dir, p2_ifg, p2_ies, p2_ie, p2_sel;
    logic [7:0] p1_periph; // Peripheral output per port one bit
    logic [7:0] p2_periph; // Peripheral output per port two bit
    logic [7:0] p1_drive, p1_oe_n, p2_drive, p2_oe_n;
    logic [7:0] p2_pad_in; // Port two input with padless and cut bits forced
    logic p1_irq, p2_irq;

    // Accept each write half on its own, answer once both are held
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_lane0 = wstrb_reg[0];
    assign wr_data = wdata_reg[7:0];
    assign wr_hit = (awaddr_reg[1:0] == 2'h0) &&
        ((awaddr_reg >= dpg_pkg::DPG_P1_OUT && awaddr_reg <= dpg_pkg::DPG_P1_SEL) ||
         (awaddr_reg >= dpg_pkg::DPG_P2_OUT && awaddr_reg <= dpg_pkg::DPG_P2_SEL));
    assign w1_out = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P1_OUT;
    assign w1_dir = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P1_DIR;
    assign w1_ifg = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P1_IFG;
    assign w1_ies = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P1_IES;
    assign w1_ie = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P1_IE;
    assign w1_sel = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P1_SEL;
    assign w2_out = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P2_OUT;
    assign w2_dir = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P2_DIR;
    assign w2_ifg = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P2_IFG;
    assign w2_ies = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P2_IES;
    assign w2_ie = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P2_IE;
    assign w2_sel = wr_fire && wr_lane0 && awaddr_reg == dpg_pkg::DPG_P2_SEL;

    // Read decode; the input image is read-only
    assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
    assign araddr_q = s_axi_araddr;
    always_comb begin
        rdata_next = 32'h0000_0000;
        rresp_next = dpg_pkg::DPG_RESP_OKAY;
        case (araddr_q)
            dpg_pkg::DPG_P1_IN: rdata_next[7:0] = p1_in;
            dpg_pkg::DPG_P1_OUT: rdata_next[7:0] = p1_out;
            dpg_pkg::DPG_P1_DIR: rdata_next[7:0] = p1_dir;
            dpg_pkg::DPG_P1_IFG: rdata_next[7:0] = p1_ifg;
            dpg_pkg::DPG_P1_IES: rdata_next[7:0] = p1_ies;
            dpg_pkg::DPG_P1_IE: rdata_next[7:0] = p1_ie;
            dpg_pkg::DPG_P1_SEL: rdata_next[7:0] = p1_sel;
            dpg_pkg::DPG_P2_IN: rdata_next[7:0] = p2_in;
            dpg_pkg::DPG_P2_OUT: rdata_next[7:0] = p2_out;
            dpg_pkg::DPG_P2_DIR: rdata_next[7:0] = p2_dir;
            dpg_pkg::DPG_P2_IFG: rdata_next[7:0] = p2_ifg;
            dpg_pkg::DPG_P2_IES: rdata_next[7:0] = p2_ies;
            dpg_pkg::DPG_P2_IE: rdata_next[7:0] = p2_ie;
            dpg_pkg::DPG_P2_SEL: rdata_next[7:0] = p2_sel;
            default: rresp_next = dpg_pkg::DPG_RESP_SLVERR;
        endcase
    end

    // Peripheral outputs per bit; tied-low functions pull the pad low
    assign p1_periph = {timer_output_2_i, timer_output_1_i, timer_output_0_i,
        subsystem_clock_i, timer_output_2_i, timer_output_1_i, timer_output_0_i,
        1'b0};
    assign p2_periph = {2'b00, 1'b0, timer_output_2_i, timer_output_1_i,
        timer_output_0_i, 1'b0, aux_clock_i};
    // Padless bits see constant low so no edge appears; bit 5 low when cut
    assign p2_pad_in = {2'b00,
        port_two_pad_i[5] & ~ext_resistor_select_i, port_two_pad_i[4:0]};

    // Write channel: hold address and data independently until both arrive
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Bus handshake outputs, all registered
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dpg_pkg::DPG_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dpg_pkg::DPG_RESP_OKAY;
        end else begin
            // Ready only while the slot is empty and not just taken
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? dpg_pkg::DPG_RESP_OKAY : dpg_pkg::DPG_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Read: arready pulses with the capture, data one cycle later
            s_axi_arready <= rd_fire && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_next;
                s_axi_rresp <= rresp_next;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Port one: all eight bits have pads and edge flags
    dpg_port #(.EDGE_MASK(8'hFF)) u_port_one (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .wdata_i(wr_data),
        .wr_out_i(w1_out), .wr_dir_i(w1_dir), .wr_ifg_i(w1_ifg),
        .wr_ies_i(w1_ies), .wr_ie_i(w1_ie), .wr_sel_i(w1_sel),
        .pad_in_i(port_one_pad_i), .periph_out_i(p1_periph),
        .in_o(p1_in), .out_o(p1_out), .dir_o(p1_dir), .ifg_o(p1_ifg),
        .ies_o(p1_ies), .ie_o(p1_ie), .sel_o(p1_sel),
        .pad_drive_o(p1_drive), .pad_oe_n_o(p1_oe_n), .irq_o(p1_irq)
    );

    // Port two: bits 6 and 7 are masked from edge flags
    dpg_port #(.EDGE_MASK(dpg_pkg::DPG_P2_PAD_MASK)) u_port_two (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .wdata_i(wr_data),
        .wr_out_i(w2_out), .wr_dir_i(w2_dir), .wr_ifg_i(w2_ifg),
        .wr_ies_i(w2_ies), .wr_ie_i(w2_ie), .wr_sel_i(w2_sel),
        .pad_in_i(p2_pad_in), .periph_out_i(p2_periph),
        .in_o(p2_in), .out_o(p2_out), .dir_o(p2_dir), .ifg_o(p2_ifg),
        .ies_o(p2_ies), .ie_o(p2_ie), .sel_o(p2_sel),
        .pad_drive_o(p2_drive), .pad_oe_n_o(p2_oe_n), .irq_o(p2_irq)
    );

    // Pad, capture and interrupt outputs, re-registered at the top boundary
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_one_pad_o <= 8'h00;
            port_one_pad_oe_n_o <= 8'hFF;
            port_two_pad_o <= 6'h00;
            port_two_pad_oe_n_o <= 6'h3F;
            timer_ext_clock_in_o <= 1'b0;
            timer_alt_clock_in_o <= 1'b0;
            capture0_input_a_o <= 1'b0;
            capture1_input_a_o <= 1'b0;
            capture2_input_a_o <= 1'b0;
            capture0_input_b_o <= 1'b0;
            capture1_input_b_o <= 1'b0;
            port_one_irq_o <= 1'b0;
            port_two_irq_o <= 1'b0;
        end else begin
            port_one_pad_o <= p1_drive;
            port_one_pad_oe_n_o <= p1_oe_n;
            port_two_pad_o <= p2_drive[5:0];
            // Resistor control cuts bit 5 off its pad: no drive at all
            port_two_pad_oe_n_o <= {p2_oe_n[5] | ext_resistor_select_i, p2_oe_n[4:0]};
            // Peripheral inputs follow the synchronized pad while selected
            timer_ext_clock_in_o <= p1_sel[0] & p1_in[0];
            capture0_input_a_o <= p1_sel[1] & p1_in[1];
            capture1_input_a_o <= p1_sel[2] & p1_in[2];
            capture2_input_a_o <= p1_sel[3] & p1_in[3];
            timer_alt_clock_in_o <= p2_sel[1] & p2_in[1];
            capture0_input_b_o <= p2_sel[2] & p2_in[2];
            capture1_input_b_o <= p2_sel[3] & p2_in[3];
            port_one_irq_o <= p1_irq;
            port_two_irq_o <= p2_irq;
        end
    end
endmodule

// ### sim/dpg_pad_model.sv
// Board model for both pad rows: block drive where enabled, board level elsewhere
`timescale 1ns/100ps
module dpg_pad_model (
    input wire logic [7:0] p1_drive_i,
    input wire logic [7:0] p1_oe_n_i,
    input wire logic [7:0] p1_board_i,
    output logic [7:0] p1_pad_o,
    input wire logic [5:0] p2_drive_i,
    input wire logic [5:0] p2_oe_n_i,
    input wire logic [5:0] p2_board_i,
    output logic [5:0] p2_pad_o
);
    // Enable is active low; the board only shows through where the block is quiet
    assign p1_pad_o = (~p1_oe_n_i & p1_drive_i) | (p1_oe_n_i & p1_board_i);
    // Same resolution for the six bonded bits of port two
    assign p2_pad_o = (~p2_oe_n_i & p2_drive_i) | (p2_oe_n_i & p2_board_i);
endmodule

// ### sim/dpg_gpio_assertions.sv
// Checker watching the pin block top ports
`timescale 1ns/100ps
module dpg_gpio_assertions (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0] port_one_pad_i,
    input wire logic [5:0] port_two_pad_i,
    input wire logic [7:0] port_one_pad_oe_n_o,
    input wire logic [5:0] port_two_pad_oe_n_o,
    input wire logic ext_resistor_select_i,
    input wire logic timer_ext_clock_in_o,
    input wire logic timer_alt_clock_in_o,
    input wire logic capture0_input_a_o,
    input wire logic capture0_input_b_o
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    // Peripheral inputs may only be high if the pad was high a sync delay earlier
    property p_ext_clk;
        timer_ext_clock_in_o |-> $past(port_one_pad_i[0], 3) || $past(port_one_pad_i[0], 4);
    endproperty
    a_ext_clk: assert property (p_ext_clk) else $error("ext clock high without pad");
    property p_cap0a;
        capture0_input_a_o |-> $past(port_one_pad_i[1], 3) || $past(port_one_pad_i[1], 4);
    endproperty
    a_cap0a: assert property (p_cap0a) else $error("capture a0 high without pad");
    property p_alt_clk;
        timer_alt_clock_in_o |-> $past(port_two_pad_i[1], 3) || $past(port_two_pad_i[1], 4);
    endproperty
    a_alt_clk: assert property (p_alt_clk) else $error("alt clock high without pad");
    property p_cap0b;
        capture0_input_b_o |-> $past(port_two_pad_i[2], 3) || $past(port_two_pad_i[2], 4);
    endproperty
    a_cap0b: assert property (p_cap0b) else $error("capture b0 high without pad");
    // Resistor control held must leave bit five undriven
    property p_osc_resistor_pin_cut;
        ext_resistor_select_i [*3] |-> port_two_pad_oe_n_o[5];
    endproperty
    a_osc_resistor_pin_cut: assert property (p_osc_resistor_pin_cut) else $error("bit five driven while cut");
    // Port one driver enables move only after a register write, never by peripheral action
    property p_dir_only;
        (!(s_axi_wvalid && s_axi_wready)) [*6] |=> $stable(port_one_pad_oe_n_o);
    endproperty
    a_dir_only: assert property (p_dir_only) else $error("enable changed without write");
    // Bus answers stand until taken
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped or changed");
endmodule
bind dpg_gpio dpg_gpio_assertions dpg_gpio_assertions_inst (.*);

// ### sim/dpg_gpio_test.sv
// Self-checking bench for the pin block over its register bus
`timescale 1ns/100ps
module dpg_gpio_test;
    localparam logic [1:0] OK = dpg_pkg::DPG_RESP_OKAY;
    localparam logic [1:0] ER = dpg_pkg::DPG_RESP_SLVERR;
    logic mclk_i, arst_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, port_one_pad_i, port_one_pad_o, port_one_pad_oe_n_o;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] port_two_pad_i, port_two_pad_o, port_two_pad_oe_n_o, p2_board;
    logic [7:0] p1_board;
    logic timer_output_0_i, timer_output_1_i, timer_output_2_i, subsystem_clock_i, aux_clock_i;
    logic ext_resistor_select_i, timer_ext_clock_in_o, timer_alt_clock_in_o, capture0_input_a_o;
    logic capture1_input_a_o, capture2_input_a_o, capture0_input_b_o, capture1_input_b_o;
    logic port_one_irq_o, port_two_irq_o;
    int err_total = 0;
    int checked = 0;
    // Every bench signal on the pin block carries the name of the port it meets there
    dpg_gpio dpg_gpio_inst (.*);
    dpg_pad_model dpg_pad_model_inst (.p1_drive_i(port_one_pad_o), .p1_oe_n_i(port_one_pad_oe_n_o),
        .p1_board_i(p1_board), .p1_pad_o(port_one_pad_i), .p2_drive_i(port_two_pad_o),
        .p2_oe_n_i(port_two_pad_oe_n_o), .p2_board_i(p2_board), .p2_pad_o(port_two_pad_i));
    // Free-running system clock, 10 ns period
    always #5 mclk_i = ~mclk_i;
    // Compare one byte-wide result and count it
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Write with both address and data offered; answer taken one edge after it shows
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge mclk_i);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge mclk_i);
        s_axi_bready <= 1'b1;
        @(posedge mclk_i);
        chk("bresp", 8'(er), 8'(s_axi_bresp));
        s_axi_bready <= 1'b0;
    endtask
    // Read and compare; late ready makes the slave hold its answer a cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge mclk_i);
        while (!s_axi_arready) @(posedge mclk_i);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge mclk_i);
        s_axi_rready <= 1'b1;
        @(posedge mclk_i);
        chk("rresp", 8'(er), 8'(s_axi_rresp));
        if (er === OK) chk("rdata", e, s_axi_rdata[7:0]);
        s_axi_rready <= 1'b0;
    endtask
    // Pad to register path is three edges; six covers it with margin
    task automatic settle;
        repeat (6) @(posedge mclk_i);
    endtask
    task automatic wrap_up;
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        wrap_up();
    end
    initial begin
        mclk_i = 0;
        arst_n_i = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {p1_board, p2_board, ext_resistor_select_i} = '0;
        {timer_output_0_i, timer_output_1_i, timer_output_2_i, subsystem_clock_i, aux_clock_i} = '0;
        repeat (8) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        // Reset values, then pattern write and readback of every control register
        for (int i = 1; i < 7; i++) rd(dpg_pkg::DPG_P1_IN + 8'(4 * i), 8'h00, OK);
        for (int i = 1; i < 7; i++) rd(dpg_pkg::DPG_P2_IN + 8'(4 * i), 8'h00, OK);
        for (int i = 1; i < 7; i++) wr(dpg_pkg::DPG_P1_IN + 8'(4 * i), 8'hA5, OK);
        for (int i = 1; i < 7; i++) wr(dpg_pkg::DPG_P2_IN + 8'(4 * i), 8'hA5, OK);
        for (int i = 1; i < 7; i++) rd(dpg_pkg::DPG_P1_IN + 8'(4 * i), 8'hA5, OK);
        for (int i = 1; i < 7; i++) rd(dpg_pkg::DPG_P2_IN + 8'(4 * i), 8'hA5, OK);
        chk("irq1", 8'h01, 8'(port_one_irq_o));
        for (int i = 6; i > 0; i--) wr(dpg_pkg::DPG_P1_IN + 8'(4 * i), 8'h00, OK);
        for (int i = 6; i > 0; i--) wr(dpg_pkg::DPG_P2_IN + 8'(4 * i), 8'h00, OK);
        // Refused accesses: read-only input, unmapped and misaligned
        wr(dpg_pkg::DPG_P1_IN, 8'hFF, ER);
        wr(8'h40, 8'hFF, ER);
        rd(8'h02, 8'h00, ER);
        // Plain output drive and input sampling
        wr(dpg_pkg::DPG_P1_DIR, 8'hFF, OK);
        wr(dpg_pkg::DPG_P1_OUT, 8'h5A, OK);
        settle();
        chk("p1 pad", 8'h5A, port_one_pad_o);
        chk("p1 oe_n", 8'h00, port_one_pad_oe_n_o);
        rd(dpg_pkg::DPG_P1_IN, 8'h5A, OK);
        p2_board <= 6'h2B;
        settle();
        rd(dpg_pkg::DPG_P2_IN, 8'h2B, OK);
        // Resistor control cuts bit five from its pad
        p2_board <= 6'h3F;
        ext_resistor_select_i <= 1'b1;
        wr(dpg_pkg::DPG_P2_DIR, 8'h20, OK);
        settle();
        chk("p2 oe_n5", 8'h01, 8'(port_two_pad_oe_n_o[5]));
        rd(dpg_pkg::DPG_P2_IN, 8'h1F, OK);
        ext_resistor_select_i <= 1'b0;
        settle();
        chk("p2 oe_n5", 8'h00, 8'(port_two_pad_oe_n_o[5]));
        // Port one functions: timer outputs, subsystem clock, low on bit 0
        {timer_output_0_i, timer_output_1_i, timer_output_2_i, subsystem_clock_i} <= 4'b1011;
        wr(dpg_pkg::DPG_P1_SEL, 8'hFF, OK);
        settle();
        chk("p1 fn pad", 8'hBA, port_one_pad_o);
        chk("p1 fn oe_n", 8'h00, port_one_pad_oe_n_o);
        wr(dpg_pkg::DPG_P1_DIR, 8'h00, OK);
        p1_board <= 8'h0F;
        settle();
        chk("p1 oe_n", 8'hFF, port_one_pad_oe_n_o);
        chk("p1 caps", 8'h0F, 8'({capture2_input_a_o, capture1_input_a_o, capture0_input_a_o,
            timer_ext_clock_in_o}));
        p1_board <= 8'h00;
        settle();
        chk("p1 caps", 8'h00, 8'({capture2_input_a_o, capture1_input_a_o, capture0_input_a_o,
            timer_ext_clock_in_o}));
        // Port two functions: aux clock, forced lows, timer outputs, alternate inputs
        aux_clock_i <= 1'b1;
        wr(dpg_pkg::DPG_P2_OUT, 8'h3F, OK);
        wr(dpg_pkg::DPG_P2_DIR, 8'h3F, OK);
        wr(dpg_pkg::DPG_P2_SEL, 8'h3F, OK);
        settle();
        chk("p2 fn pad", 8'h15, 8'(port_two_pad_o));
        wr(dpg_pkg::DPG_P2_DIR, 8'h00, OK);
        p2_board <= 6'h0E;
        settle();
        chk("p2 caps", 8'h07, 8'({capture1_input_b_o, capture0_input_b_o, timer_alt_clock_in_o}));
        // Edge flags: rising on bit 0, falling on bit 1
        wr(dpg_pkg::DPG_P1_SEL, 8'h00, OK);
        wr(dpg_pkg::DPG_P1_IES, 8'h02, OK);
        wr(dpg_pkg::DPG_P1_IFG, 8'h00, OK);
        wr(dpg_pkg::DPG_P1_IE, 8'h03, OK);
        chk("irq1 idle", 8'h00, 8'(port_one_irq_o));
        p1_board <= 8'h01;
        settle();
        chk("irq1 rise", 8'h01, 8'(port_one_irq_o));
        p1_board <= 8'h02;
        settle();
        rd(dpg_pkg::DPG_P1_IFG, 8'h01, OK);
        p1_board <= 8'h00;
        settle();
        rd(dpg_pkg::DPG_P1_IFG, 8'h03, OK);
        wr(dpg_pkg::DPG_P1_IFG, 8'h00, OK);
        settle();
        chk("irq1 clr", 8'h00, 8'(port_one_irq_o));
        // Padless bits: pad edges never touch them, software raises them
        wr(dpg_pkg::DPG_P2_SEL, 8'h00, OK);
        p2_board <= 6'h00;
        settle();
        wr(dpg_pkg::DPG_P2_IFG, 8'h00, OK);
        wr(dpg_pkg::DPG_P2_IE, 8'hC0, OK);
        p2_board <= 6'h3F;
        settle();
        rd(dpg_pkg::DPG_P2_IFG, 8'h3F, OK);
        chk("irq2 idle", 8'h00, 8'(port_two_irq_o));
        wr(dpg_pkg::DPG_P2_IFG, 8'hC0, OK);
        settle();
        chk("irq2 soft", 8'h01, 8'(port_two_irq_o));
        wrap_up();
    end
endmodule
